// ===== biar_map.vh
`ifndef BIAR_MAP_VH
`define BIAR_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define BIAR_OFS_CTRL      8'h00
`define BIAR_OFS_VBASE     8'h04
`define BIAR_OFS_MASK      8'h08
`define BIAR_OFS_SNAP      8'h0c
`define BIAR_OFS_GBYTE     8'h10
`define BIAR_OFS_GCHAN     8'h14
`define BIAR_OFS_GRX       8'h18
`define BIAR_OFS_GTX       8'h1c
`define BIAR_OFS_STATUS    8'h20
`define BIAR_OFS_PRIO      8'h24

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define BIAR_CTRL_THR_HI   7
`define BIAR_CTRL_THR_LO   2
`define BIAR_CTRL_FMT_HI   1
`define BIAR_CTRL_FMT_LO   0

// ------------------------------------------------------------
// Vector formats
// ------------------------------------------------------------
`define BIAR_FMT_FULL      2'h0
`define BIAR_FMT_CHAN      2'h1
`define BIAR_FMT_TYPE      2'h2
`define BIAR_FMT_INHIBIT   2'h3

// ------------------------------------------------------------
// Source identifiers, bid bits 4:2
// ------------------------------------------------------------
`define BIAR_ID_RX_ERR     3'h7
`define BIAR_ID_RX_OK      3'h3
`define BIAR_ID_TX_LOW     2'h2
`define BIAR_ID_BREAK      3'h4
`define BIAR_ID_COS        3'h1
`define BIAR_ID_CT         3'h5
`define BIAR_ID_NONE       3'h0

// ------------------------------------------------------------
// Mask register layout: base bit of each source group
// ------------------------------------------------------------
`define BIAR_MASK_RX       0
`define BIAR_MASK_TX       4
`define BIAR_MASK_BRK      8
`define BIAR_MASK_COS      12
`define BIAR_MASK_CT       16

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BIAR_RST_CTRL      8'h00
`define BIAR_RST_VBASE     8'h0f
`define BIAR_RST_MASK      18'h00000
`define BIAR_RST_PRIO      28'h0000000
`define BIAR_RST_SNAP      8'h00

`endif

// ===== biar_bid_src.v
`timescale 1ns/1ns

// Forms one source's bid, re-evaluated on every crystal clock edge.
// A source that is masked off or has nothing pending bids all zeros.
module biar_bid_src (
	input  wire       clk,
	input  wire       srst,
	input  wire       allow,
	input  wire       request,
	input  wire [2:0] upper,
	input  wire [2:0] ident,
	input  wire [1:0] chan,
	output reg  [7:0] bid
);

	// ------------------------------------------------------------
	// Bid register
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			bid <= 8'h00;
		end else if (allow && request) begin // RULE20
			bid <= {upper, ident, chan}; // RULE10
		end else begin
			bid <= 8'h00; // RULE15 RULE16
		end
	end

endmodule

// ===== biar_arbiter.v
//
// Contract
// RULE1: Exactly eighteen interrupt sources accepted
// RULE2: Bids compared to threshold every clock
// RULE3: Request only when bid exceeds threshold
// RULE4: Snapshot latched on acknowledge or command
// RULE5: Snapshot holds channel, type, byte count
// RULE6: Snapshot drives vector and global decode
// RULE7: Global receive reads snapshot channel's FIFO
// RULE8: Global transmit writes snapshot channel's FIFO
// RULE9: Global count and channel read snapshot
// RULE10: Identifier bits 4:2, channel lowest
// RULE11: Rx error 111, Rx 011, Tx x10
// RULE12: Break 100, COS 001, timer 101
// RULE13: Numerically largest bid wins arbitration
// RULE14: Non-data upper bits are programmable; the timer bids take bits 7:6 from prio_reg and hardwire bit 5 to 0
// RULE15: Timer bids only after timing out
// RULE16: Empty receiver, full transmitter never bid
// RULE17: Threshold is six bits wide
// RULE18: Threshold against upper six; channel D wins ties
// RULE19: Two control bits select vector format
// RULE20: Mask bits enable each source's bid
// RULE21: Request drops once no bid exceeds
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "biar_map.vh"

module biar_arbiter #(
	parameter NCH = 4,
	parameter NSRC = 18
) (
	input  wire                clk,
	input  wire                srst,
	// APB slave
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr,
	// Channel conditions
	input  wire [NCH-1:0]      rx_empty,
	input  wire [NCH-1:0]      rx_error,
	input  wire [2*NCH-1:0]    rx_count,
	input  wire [8*NCH-1:0]    rx_data,
	input  wire [NCH-1:0]      tx_full,
	input  wire [3*NCH-1:0]    tx_count,
	input  wire [NCH-1:0]      break_pending,
	input  wire [NCH-1:0]      cos_pending,
	input  wire [1:0]          ct_timeout,
	output reg                 rx_pop,
	output reg  [1:0]          rx_pop_chan,
	output reg                 tx_push,
	output reg  [1:0]          tx_push_chan,
	output reg  [7:0]          tx_push_data,
	// Interrupt pins
	input  wire                interrupt_acknowledge_n,
	input  wire                irq_n_in,
	output reg                 irq_n_out,
	output reg                 irq_n_oe,
	output reg  [7:0]          vector_out,
	output reg                 vector_valid
);

	// ------------------------------------------------------------
	// Software state
	// ------------------------------------------------------------
	reg  [7:0]          interrupt_control_reg;
	reg  [7:0]          vector_base_reg;
	reg  [NSRC-1:0]     source_mask_reg;
	reg  [27:0]         prio_reg;
	reg  [7:0]          current_interrupt_snapshot;
	reg  [7:0]          best_bid;
	reg                 iack_d;

	wire [8*NSRC-1:0]   bids;
	wire [5:0]          threshold;
	wire [1:0]          vec_fmt;

	// RULE17
	assign threshold = interrupt_control_reg[`BIAR_CTRL_THR_HI:
	                                         `BIAR_CTRL_THR_LO];
	assign vec_fmt   = interrupt_control_reg[`BIAR_CTRL_FMT_HI:
	                                         `BIAR_CTRL_FMT_LO];

	// ------------------------------------------------------------
	// Source bids
	// ------------------------------------------------------------
	// Per channel: receiver, transmitter, break and change of state.
	// Channel index sits in the low bid bits so channel D is strongest.
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_chan
			// Channel number as a constant word, so its low bits can be cut
			localparam [31:0] chan_num = g;
			// RULE11
			biar_bid_src u_rx (
				.clk     (clk),
				.srst    (srst),
				.allow   (source_mask_reg[`BIAR_MASK_RX + g]),
				.request (~rx_empty[g]),
				.upper   ({1'b1, rx_count[2*g+1:2*g]}),
				.ident   (rx_error[g] ? `BIAR_ID_RX_ERR : `BIAR_ID_RX_OK),
				.chan    (chan_num[1:0]),
				.bid     (bids[8*g+7:8*g])
			);
			// Transmit count spills into bit 4, hence the x10 code
			biar_bid_src u_tx (
				.clk     (clk),
				.srst    (srst),
				.allow   (source_mask_reg[`BIAR_MASK_TX + g]),
				.request (~tx_full[g]),
				.upper   ({1'b0, tx_count[3*g+2:3*g+1]}),
				.ident   ({tx_count[3*g], `BIAR_ID_TX_LOW}),
				.chan    (chan_num[1:0]),
				.bid     (bids[8*(g+NCH)+7:8*(g+NCH)])
			);
			// RULE12 RULE14
			biar_bid_src u_brk (
				.clk     (clk),
				.srst    (srst),
				.allow   (source_mask_reg[`BIAR_MASK_BRK + g]),
				.request (break_pending[g]),
				.upper   (prio_reg[3*g+2:3*g]),
				.ident   (`BIAR_ID_BREAK),
				.chan    (chan_num[1:0]),
				.bid     (bids[8*(g+2*NCH)+7:8*(g+2*NCH)])
			);
			biar_bid_src u_cos (
				.clk     (clk),
				.srst    (srst),
				.allow   (source_mask_reg[`BIAR_MASK_COS + g]),
				.request (cos_pending[g]),
				.upper   (prio_reg[3*g+14:3*g+12]),
				.ident   (`BIAR_ID_COS),
				.chan    (chan_num[1:0]),
				.bid     (bids[8*(g+3*NCH)+7:8*(g+3*NCH)])
			);
		end
		// Counter/timers bid only once timed out; bit 5 is hardwired 0
		for (g = 0; g < 2; g = g + 1) begin : g_ct
			localparam [31:0] timer_num = g;
			biar_bid_src u_ct (
				.clk     (clk),
				.srst    (srst),
				.allow   (source_mask_reg[`BIAR_MASK_CT + g]),
				.request (ct_timeout[g]), // RULE15
				.upper   ({prio_reg[2*g+25:2*g+24], 1'b0}),
				.ident   (`BIAR_ID_CT),
				.chan    (timer_num[1:0]),
				.bid     (bids[8*(g+4*NCH)+7:8*(g+4*NCH)])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	// Largest bid value wins; a full 8-bit compare makes the
	// channel number break ties without a separate stage.
	reg [7:0] next_best;
	integer   i;
	always @* begin
		next_best = 8'h00;
		for (i = 0; i < NSRC; i = i + 1) begin // RULE1
			if (bids[8*i +: 8] > next_best) begin // RULE13 RULE18
				next_best = bids[8*i +: 8];
			end
		end
	end

	// Winner held one cycle so request and snapshot see the same bid
	always @(posedge clk) begin
		if (srst) begin
			best_bid <= 8'h00;
		end else begin
			best_bid <= next_best; // RULE2
		end
	end

	// ------------------------------------------------------------
	// Interrupt request pin
	// ------------------------------------------------------------
	// Open drain: only ever pulls low; no sticky state, so it lets go
	// the cycle after the winning bid falls to the threshold.
	always @(posedge clk) begin
		if (srst) begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= 1'b0;
		end else begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= (best_bid[7:2] > threshold); // RULE3 RULE18 RULE21
		end
	end

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup_rd  = psel && !penable && !pwrite;
	wire acc_done  = psel && penable && pready;
	wire wr_done   = acc_done && pwrite;
	wire rd_done   = acc_done && !pwrite;
	wire iack_fall = iack_d && !interrupt_acknowledge_n;
	wire refresh   = wr_done && (paddr == `BIAR_OFS_SNAP);
	wire mapped    = (paddr == `BIAR_OFS_CTRL)  ||
	                 (paddr == `BIAR_OFS_VBASE) ||
	                 (paddr == `BIAR_OFS_MASK)  ||
	                 (paddr == `BIAR_OFS_SNAP)  ||
	                 (paddr == `BIAR_OFS_GBYTE) ||
	                 (paddr == `BIAR_OFS_GCHAN) ||
	                 (paddr == `BIAR_OFS_GRX)   ||
	                 (paddr == `BIAR_OFS_GTX)   ||
	                 (paddr == `BIAR_OFS_STATUS)||
	                 (paddr == `BIAR_OFS_PRIO);
	wire [1:0] snap_chan = current_interrupt_snapshot[1:0];

	// ------------------------------------------------------------
	// Snapshot capture
	// ------------------------------------------------------------
	// Taken on the acknowledge falling edge or a write to the snapshot
	// location, whatever data the write carries.
	always @(posedge clk) begin
		if (srst) begin
			iack_d                     <= 1'b1;
			current_interrupt_snapshot <= `BIAR_RST_SNAP;
		end else begin
			iack_d <= interrupt_acknowledge_n;
			if (iack_fall || refresh) begin
				current_interrupt_snapshot <= best_bid; // RULE4 RULE5
			end
		end
	end

	// ------------------------------------------------------------
	// Vector output
	// ------------------------------------------------------------
	// Built from the bid being captured, so vector and snapshot agree.
	reg [7:0] next_vector;
	always @* begin
		case (vec_fmt) // RULE19
			`BIAR_FMT_FULL:
				next_vector = vector_base_reg;
			`BIAR_FMT_CHAN:
				next_vector = {vector_base_reg[7:2], best_bid[1:0]};
			`BIAR_FMT_TYPE:
				next_vector = {vector_base_reg[7:5], best_bid[4:0]};
			default:
				next_vector = 8'hff;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			vector_out   <= 8'hff;
			vector_valid <= 1'b0;
		end else begin
			if (iack_fall) begin
				vector_out <= next_vector; // RULE6
			end
			vector_valid <= !interrupt_acknowledge_n;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			interrupt_control_reg <= `BIAR_RST_CTRL;
			vector_base_reg       <= `BIAR_RST_VBASE;
			source_mask_reg       <= `BIAR_RST_MASK;
			prio_reg              <= `BIAR_RST_PRIO;
		end else if (wr_done) begin
			case (paddr)
				`BIAR_OFS_CTRL:
					interrupt_control_reg <= pwdata[7:0];
				`BIAR_OFS_VBASE:
					vector_base_reg <= pwdata[7:0];
				`BIAR_OFS_MASK:
					source_mask_reg <= pwdata[NSRC-1:0];
				`BIAR_OFS_PRIO:
					prio_reg <= pwdata[27:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Global FIFO strobes
	// ------------------------------------------------------------
	// One-cycle strobes steered by the snapshot channel; the channel
	// logic must accept them without back-pressure.
	always @(posedge clk) begin
		if (srst) begin
			rx_pop       <= 1'b0;
			rx_pop_chan  <= 2'h0;
			tx_push      <= 1'b0;
			tx_push_chan <= 2'h0;
			tx_push_data <= 8'h00;
		end else begin
			rx_pop  <= rd_done && (paddr == `BIAR_OFS_GRX); // RULE7
			tx_push <= wr_done && (paddr == `BIAR_OFS_GTX); // RULE8
			if (rd_done) begin
				rx_pop_chan <= snap_chan;
			end
			if (wr_done && (paddr == `BIAR_OFS_GTX)) begin
				tx_push_chan <= snap_chan; // RULE8
				tx_push_data <= pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Global locations have no storage: they are views of the snapshot.
	reg [31:0] next_rdata;
	always @* begin
		case (paddr)
			`BIAR_OFS_CTRL:   next_rdata = {24'h0, interrupt_control_reg};
			`BIAR_OFS_VBASE:  next_rdata = {24'h0, vector_base_reg};
			`BIAR_OFS_MASK:   next_rdata = {14'h0, source_mask_reg};
			`BIAR_OFS_SNAP:   next_rdata = {24'h0, current_interrupt_snapshot};
			`BIAR_OFS_GBYTE:  next_rdata = {29'h0,
			                   current_interrupt_snapshot[7:5]}; // RULE9
			`BIAR_OFS_GCHAN:  next_rdata = {30'h0, snap_chan}; // RULE9
			`BIAR_OFS_GRX:    next_rdata = {24'h0,
			                   rx_data[8*snap_chan +: 8]}; // RULE7
			`BIAR_OFS_STATUS: next_rdata = {22'h0, irq_n_in, irq_n_oe,
			                   best_bid};
			`BIAR_OFS_PRIO:   next_rdata = {4'h0, prio_reg};
			default:          next_rdata = 32'h0;
		endcase
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// Ready in the first access cycle; read data are registered in
	// the setup cycle, which costs nothing and keeps prdata a flop.
	always @(posedge clk) begin
		if (srst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			if (setup_rd) begin
				prdata <= next_rdata;
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// ===== biar_monitor.sv
`timescale 1ns/1ns
`include "biar_map.vh"

module biar_monitor #(
	parameter NCH  = 4,
	parameter NSRC = 18
) (
	input wire		clk,
	input wire		srst,
	input wire		psel,
	input wire		penable,
	input wire		pwrite,
	input wire [7:0]	paddr,
	input wire [31:0]	pwdata,
	input wire [31:0]	prdata,
	input wire		pready,
	input wire [NCH-1:0]	rx_empty,
	input wire [NCH-1:0]	tx_full,
	input wire [NCH-1:0]	break_pending,
	input wire [NCH-1:0]	cos_pending,
	input wire [1:0]	ct_timeout,
	input wire		rx_pop,
	input wire		tx_push,
	input wire [7:0]	tx_push_data,
	input wire		interrupt_acknowledge_n,
	input wire		irq_n_oe,
	input wire [7:0]	vector_out,
	input wire		vector_valid
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	reg [1:0] fmt_q;
	wire acc = psel && penable && pready;
	// No source can bid at all: nothing may hold the request
	wire idle = (&rx_empty) && (&tx_full) && !(|break_pending) &&
		!(|cos_pending) && !(|ct_timeout);
	// Mirror of the vector format, changed only by completed writes
	always @(posedge clk) begin
		if (srst)
			fmt_q <= 2'h0;
		else if (acc && pwrite && paddr == `BIAR_OFS_CTRL)
			fmt_q <= pwdata[1:0];
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_setup; psel && !penable; endsequence
	sequence s_ack; $fell(interrupt_acknowledge_n); endsequence
	property p_ready; s_setup |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no pready");
	property p_quiet; idle [*4] |-> !irq_n_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("irq held");
	property p_vv_rise; s_ack |-> ##[1:2] vector_valid; endproperty
	a_vv_rise: assert property (p_vv_rise) else $error("no vv");
	property p_vv_fall;
		interrupt_acknowledge_n [*3] |-> !vector_valid;
	endproperty
	a_vv_fall: assert property (p_vv_fall) else $error("vv");
	property p_inhibit;
		s_ack ##0 (fmt_q == 2'h3) |-> ##[1:3] (vector_out == 8'hff);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("vec");
	property p_rx_pop;
		rx_pop == $past(acc && !pwrite && paddr == `BIAR_OFS_GRX);
	endproperty
	a_rx_pop: assert property (p_rx_pop) else $error("pop");
	property p_tx_push;
		acc && pwrite && paddr == `BIAR_OFS_GTX |=>
			tx_push && tx_push_data == $past(pwdata[7:0]);
	endproperty
	a_tx_push: assert property (p_tx_push) else $error("push");
	property p_gchan;
		acc && !pwrite && paddr == `BIAR_OFS_GCHAN |-> prdata[31:2] == 0;
	endproperty
	a_gchan: assert property (p_gchan) else $error("gchan");
endmodule

bind biar_arbiter biar_monitor #(.NCH(NCH), .NSRC(NSRC)) u_biar_monitor (
	.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .rx_empty, .tx_full, .break_pending, .cos_pending,
	.ct_timeout, .rx_pop, .tx_push, .tx_push_data,
	.interrupt_acknowledge_n, .irq_n_oe, .vector_out, .vector_valid
);

// ===== biar_chan_model.sv
`timescale 1ns/1ns

module biar_chan_model (
	input wire		clk,
	input wire		srst,
	input wire		rx_pop,
	input wire [1:0]	rx_pop_chan,
	input wire		tx_push,
	input wire [1:0]	tx_push_chan,
	input wire [7:0]	tx_push_data,
	output reg [31:0]	rx_data,
	output reg [31:0]	tx_seen
);
	// Each pop moves that FIFO head on, so a stale read is caught
	always @(posedge clk) begin
		if (srst) begin
			rx_data <= 32'h3f2f1f0f;
			tx_seen <= 32'h0;
		end else begin
			if (rx_pop)
				rx_data[rx_pop_chan*8+:8] <= rx_data[rx_pop_chan*8+:8] + 1;
			if (tx_push)
				tx_seen[tx_push_chan*8+:8] <= tx_push_data;
		end
	end
endmodule

// ===== biar_arbiter_bench.sv
`timescale 1ns/1ns
`include "biar_map.vh"
`define check_eq(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module biar_arbiter_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	reg clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, iack_n = 1;
	reg [7:0] paddr = 0, rx_count = 0, best, vbase, exp_rx [4];
	reg [31:0] pwdata = 0, rd, d;
	reg [3:0] rx_empty = 4'hf, rx_error = 0, tx_full = 4'hf, brk = 0, cos = 0;
	reg [11:0] tx_count = 0;
	reg [1:0] ct = 0, fmt;
	reg [17:0] mask;
	reg [27:0] prio;
	reg [5:0] thr;
	reg err;
	wire [31:0] prdata, rx_data, tx_seen;
	wire [7:0] tx_push_data, vector_out;
	wire [1:0] rx_pop_chan, tx_push_chan;
	wire pready, pslverr, rx_pop, tx_push, irq_n_out, irq_n_oe, vv;
	// Open-drain request wire with its pull-up
	wire irq_n_in = irq_n_oe ? irq_n_out : 1'b1;
	int num_errors = 0, comparisons = 0;

	biar_arbiter u_biar_arbiter (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_empty(rx_empty), .rx_error(rx_error),
		.rx_count(rx_count), .rx_data(rx_data), .tx_full(tx_full),
		.tx_count(tx_count), .break_pending(brk), .cos_pending(cos),
		.ct_timeout(ct), .rx_pop(rx_pop), .rx_pop_chan(rx_pop_chan),
		.tx_push(tx_push), .tx_push_chan(tx_push_chan),
		.tx_push_data(tx_push_data), .interrupt_acknowledge_n(iack_n),
		.irq_n_in(irq_n_in), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
		.vector_out(vector_out), .vector_valid(vv));
	biar_chan_model u_biar_chan_model (.clk(clk), .srst(srst),
		.rx_pop(rx_pop), .rx_pop_chan(rx_pop_chan), .tx_push(tx_push),
		.tx_push_chan(tx_push_chan), .tx_push_data(tx_push_data),
		.rx_data(rx_data), .tx_seen(tx_seen));

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic [7:0] src_bid(input int s);
		int g;
		begin
			g = s % 4;
			src_bid = 8'h00;
			if (mask[s]) case (s / 4)
				0: if (!rx_empty[g]) src_bid = {1'b1, rx_count[2*g+:2],
					rx_error[g] ? 3'h7 : 3'h3, g[1:0]};
				1: if (!tx_full[g]) src_bid = {1'b0, tx_count[3*g+:3],
					2'h2, g[1:0]};
				2: if (brk[g]) src_bid = {prio[3*g+:3], 3'h4, g[1:0]};
				3: if (cos[g]) src_bid = {prio[3*g+12+:3], 3'h1, g[1:0]};
				default: if (ct[g]) src_bid = {prio[2*g+24+:2], 1'b0,
					3'h5, g[1:0]};
			endcase
		end
	endfunction
	function automatic [7:0] best_bid();
		best_bid = 8'h00;
		for (int s = 0; s < 18; s++)
			if (src_bid(s) > best_bid) best_bid = src_bid(s);
	endfunction
	function automatic [7:0] vec(input [1:0] f, input [7:0] v, b);
		case (f)
			2'h0: vec = v;
			2'h1: vec = {v[7:2], b[1:0]};
			2'h2: vec = {v[7:5], b[4:0]};
			default: vec = 8'hff;
		endcase
	endfunction

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// One APB transfer; the request stands until the rising edge at
	// which pready is seen high, and the answer is taken at that edge
	task automatic apb(input w, input [7:0] a, input [31:0] wd);
		int n;
		begin
			n = 0;
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1 && n < 16) begin
				@(posedge clk);
				n++;
			end
			// A slave that never answers counts as a mismatch
			if (n >= 16)
				num_errors++;
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task complete_run;
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end
	// Far above the roughly three and a half thousand cycles the tests need
	initial begin
		#2000000;
		num_errors++;
		complete_run;
	end
	initial begin
		rd = $urandom(32'ha24d);
		exp_rx = '{8'h0f, 8'h1f, 8'h2f, 8'h3f};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		apb(0, `BIAR_OFS_VBASE, 0);
		`check_eq("vbase reset", 32'h0f, rd)
		apb(0, `BIAR_OFS_MASK, 0);
		`check_eq("mask reset", 32'h0, rd)
		apb(0, 8'h30, 0);
		`check_eq("unmapped err", 1'b1, err)
		for (int it = 0; it < 80; it++) begin
			// First eighteen passes isolate one source each
			mask = it < 18 ? 18'h1 << it : 18'($urandom);
			prio = 28'($urandom);
			vbase = 8'($urandom);
			fmt = it[2:1];
			apb(1, `BIAR_OFS_MASK, {14'h0, mask});
			apb(1, `BIAR_OFS_PRIO, {4'h0, prio});
			apb(1, `BIAR_OFS_VBASE, {24'h0, vbase});
			d = it < 18 ? 32'h003ff : $urandom;
			{rx_empty, tx_full, brk, cos, ct} <= d[17:0];
			rx_error <= 4'($urandom);
			rx_count <= 8'($urandom);
			tx_count <= 12'($urandom);
			repeat (4) @(posedge clk);
			best = best_bid();
			thr = it % 3 == 2 ? 6'($urandom) : best[7:2] - 6'(it % 3);
			apb(1, `BIAR_OFS_CTRL, {24'h0, thr, fmt});
			repeat (4) @(posedge clk);
			apb(0, `BIAR_OFS_STATUS, 0);
			`check_eq("best bid", best, rd[7:0])
			`check_eq("irq", best[7:2] > thr, rd[8])
			`check_eq("irq wire", best[7:2] <= thr, rd[9])
			if (it[0])
				apb(1, `BIAR_OFS_SNAP, 0);
			else begin
				@(posedge clk) iack_n <= 1'b0;
				repeat (3) @(posedge clk);
				`check_eq("vector", vec(fmt, vbase, best), vector_out)
				`check_eq("vector valid", 1'b1, vv)
				iack_n <= 1'b1;
			end
			apb(0, `BIAR_OFS_SNAP, 0);
			`check_eq("snapshot", {24'h0, best}, rd)
			apb(0, `BIAR_OFS_GBYTE, 0);
			`check_eq("gbyte", {29'h0, best[7:5]}, rd)
			apb(0, `BIAR_OFS_GCHAN, 0);
			`check_eq("gchan", {30'h0, best[1:0]}, rd)
			apb(0, `BIAR_OFS_GRX, 0);
			`check_eq("global rx", exp_rx[best[1:0]], rd[7:0])
			exp_rx[best[1:0]]++;
			d = $urandom;
			apb(1, `BIAR_OFS_GTX, d);
			repeat (2) @(posedge clk);
			`check_eq("global tx", d[7:0], tx_seen[best[1:0]*8+:8])
		end
		complete_run;
	end
endmodule
